//--- rtl/irq_ctrl.sv
// Two-level vectored interrupt controller with a Wishbone register port.
// Assumes the core pulses instr_done_i at instruction ends and reti_done_i
// when a return-from-interrupt completes; all inputs are synchronous.
// Register writes land at the edge where the bus master sees ack high, so
// the master and the registers agree on one moment for every transfer.
// Summary of operation
// - Each external pin chooses active-low level or falling-edge sensing.
// - External pending flags sit at timer control bits 1 and 3.
// - Edge-mode external flag clears itself when the core vectors.
// - Level-mode external flag follows the pin, never latched.
// - Each source owns a fixed vector; external zero 0x0003, step eight.
// - Edge-mode external, timer zero, timer one and CAN flags clear on vectoring.
// - With auto paging on, vectoring selects the source's register page.
// - Request needs both pending flag and individual enable bit.
// - Each source has a priority bit; all reset to low.
// - High preempts low routine; nothing preempts a high routine.
// - Simultaneous requests: high level served before low.
// - Equal level ties go to the lowest slot number.
// - Requests sampled and resolved every clock.
// - Fastest response: one detect clock plus four call clocks.
// - After a return, one more instruction completes before a new call.
// - Worst case eighteen clocks follows from return plus divide timing.
// - Equal or lower request waits for return and next instruction.
// - Global enable bit 7 of main enable gates every source.
// - Flags set regardless of enable; software set acts like hardware.
// - Flag still set after return raises a new request at once.
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module irq_ctrl (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External pins and peripheral flag set pulses
  input  wire logic        ext_irq_pin_zero_n_i,
  input  wire logic        ext_irq_pin_one_n_i,
  input  wire logic [irq_ctrl_pkg::NSLOT-1:0] periph_set_i,
  // Core sequencer
  input  wire logic        instr_done_i,
  input  wire logic        reti_done_i,
  output logic             call_o,
  output logic             call_done_o,
  output logic [irq_ctrl_pkg::VW-1:0] vector_o,
  output logic [4:0]       call_slot_o,
  output logic [1:0]       special_reg_page_o,
  output logic [1:0]       in_service_o
);
  import irq_ctrl_pkg::*;

  // Vector address of a slot; slots 17 and 18 are swapped in the map
  function automatic logic [15:0] vec_of(input logic [4:0] s);
    if (s == 5'd17) vec_of = VEC_S17;
    else if (s == 5'd18) vec_of = VEC_S18;
    else vec_of = VEC_BASE + VEC_STEP * {11'h000, s};
  endfunction : vec_of

  // Register page a slot selects when auto paging is on
  function automatic logic [1:0] page_of(input logic [4:0] s);
    case (s)
      5'd10, 5'd14, 5'd19, 5'd20: page_of = 2'h1;
      5'd11, 5'd16, 5'd17, 5'd18: page_of = 2'h2;
      5'd12:                      page_of = 2'h3;
      default:                    page_of = 2'h0;
    endcase
  endfunction : page_of

  // Lowest set slot of a request vector
  function automatic logic [4:0] first_of(input logic [NSLOT-1:0] v);
    first_of = 5'h00;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (v[i]) first_of = 5'(i);
    end
  endfunction : first_of

  // Timer control, enable and priority register copies
  logic [7:0]       timer_control_reg_q;
  logic [7:0]       ie_q;
  logic [6:0]       eiea_q, eieb_q;
  logic [6:0]       ip_q, eipa_q, eipb_q;
  // Pending flags and pin history
  logic [NSLOT-1:0] flag_q, flag_d;
  logic             pin0_q, pin1_q;
  // Page switching state
  logic             auto_pg_q;
  logic [1:0]       page_q;
  // Resolved request, return hold and in-service markers
  logic             req_q, req_hi_q;
  logic [4:0]       req_slot_q;
  logic             hold_q;
  logic [1:0]       insvc_q;
  // Call sequencer
  logic [2:0]       cnt_q;
  call_st_t         st_q;
  // Strobes and per-slot enable and priority vectors
  logic             wr, vect;
  logic [NSLOT-1:0] en_vec, pri_vec, hi_req, lo_req;

  // Bus write strobe at the edge where the master samples ack high
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Vectoring moment: instruction boundary with a resolved request
  assign vect = (st_q == ST_IDLE) & instr_done_i & req_q & ~hold_q;

  // Enable and priority bits spread over slots; slot 13 stays empty
  assign en_vec  = {eieb_q, 1'b0, eiea_q, ie_q[5:0]};
  assign pri_vec = {eipb_q, 1'b0, eipa_q, ip_q[5:0]};

  // Pending and enabled, gated by the global enable
  assign hi_req = (ie_q[B_GEN] ? (flag_q & en_vec & SLOT_USED) : '0) & pri_vec;
  assign lo_req = (ie_q[B_GEN] ? (flag_q & en_vec & SLOT_USED) : '0) & ~pri_vec;

  // Wishbone ack: one cycle per request, every address answers
  // Fixed one-cycle answer, so a master never waits longer than that
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Read mux; unmapped offsets return zero
  // Data is latched at the taking edge and stands until the next request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
      case (wb_adr_i)
        A_TIMER_CONTROL_REG:  wb_dat_o <= {24'h0, flag_q[S_TF1], 1'b0, flag_q[S_TF0], 1'b0,
                              flag_q[S_EXT1], timer_control_reg_q[B_EDGE1],
                              flag_q[S_EXT0], timer_control_reg_q[B_EDGE0]};
        A_IE:    wb_dat_o <= {24'h0, ie_q};
        A_EIEA:  wb_dat_o <= {25'h0, eiea_q};
        A_EIEB:  wb_dat_o <= {25'h0, eieb_q};
        A_IP:    wb_dat_o <= {25'h0, ip_q};
        A_EIPA:  wb_dat_o <= {25'h0, eipa_q};
        A_EIPB:  wb_dat_o <= {25'h0, eipb_q};
        A_PEND:  wb_dat_o <= {11'h0, flag_q};
        A_PAGE:  wb_dat_o <= {27'h0, page_q, 2'h0, auto_pg_q};
        A_STAT:  wb_dat_o <= {16'h0, req_q, req_hi_q, req_slot_q, hold_q,
                              6'h00, insvc_q};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // Configuration registers; priorities reset low
  // Only byte lane zero carries fields; upper lanes are ignored
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      timer_control_reg_q <= RST_ZERO;
      ie_q   <= RST_ZERO;
      eiea_q <= '0;
      eieb_q <= '0;
      ip_q   <= '0;
      eipa_q <= '0;
      eipb_q <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        A_TIMER_CONTROL_REG: timer_control_reg_q <= wb_dat_i[7:0];
        A_IE:   ie_q   <= wb_dat_i[7:0];
        A_EIEA: eiea_q <= wb_dat_i[6:0];
        A_EIEB: eieb_q <= wb_dat_i[6:0];
        A_IP:   ip_q   <= wb_dat_i[6:0];
        A_EIPA: eipa_q <= wb_dat_i[6:0];
        A_EIPB: eipb_q <= wb_dat_i[6:0];
        default: ;
      endcase
    end
  end

  // Pin history for falling-edge detection
  // Reset loads the idle level so no false fall follows reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
    end else begin
      pin0_q <= ext_irq_pin_zero_n_i;
      pin1_q <= ext_irq_pin_one_n_i;
    end
  end

  // Pending flags: software write, then hardware clear, then set; set wins
  // A set pulse in a clearing cycle survives, so no event is ever lost
  always_comb begin
    flag_d = flag_q;
    if (wr && wb_adr_i == A_PEND) begin
      flag_d = wb_dat_i[NSLOT-1:0] & SLOT_USED;
    end
    if (wr && wb_adr_i == A_TIMER_CONTROL_REG) begin
      flag_d[S_EXT0] = wb_dat_i[B_PEND0];
      flag_d[S_EXT1] = wb_dat_i[B_PEND1];
      flag_d[S_TF0]  = wb_dat_i[B_TF0];
      flag_d[S_TF1]  = wb_dat_i[B_TF1];
    end
    if (vect && HW_CLR[req_slot_q]) begin
      flag_d[req_slot_q] = 1'b0;
    end
    flag_d = flag_d | (periph_set_i & SLOT_USED & ~HW_CLR) |
             (periph_set_i & (21'h1 << S_TF0 | 21'h1 << S_TF1 | 21'h1 << S_CAN));
    // External sources: edge mode latches a fall, level mode mirrors pin
    // In level mode the pin overrides any software write to the flag
    if (timer_control_reg_q[B_EDGE0]) begin
      flag_d[S_EXT0] = flag_d[S_EXT0] | (pin0_q & ~ext_irq_pin_zero_n_i);
    end else begin
      flag_d[S_EXT0] = ~ext_irq_pin_zero_n_i;
    end
    if (timer_control_reg_q[B_EDGE1]) begin
      flag_d[S_EXT1] = flag_d[S_EXT1] | (pin1_q & ~ext_irq_pin_one_n_i);
    end else begin
      flag_d[S_EXT1] = ~ext_irq_pin_one_n_i;
    end
  end

  // Flag storage
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Sample and resolve every clock: high first, lowest slot on ties
  // The request is one cycle old; vectoring drops it at once so a flag
  // cleared by that vectoring cannot start a second call
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      req_q      <= 1'b0;
      req_hi_q   <= 1'b0;
      req_slot_q <= '0;
    end else if (|hi_req && !insvc_q[1]) begin
      req_q      <= ~vect;
      req_hi_q   <= 1'b1;
      req_slot_q <= first_of(hi_req);
    end else if (|lo_req && insvc_q == 2'b00) begin
      req_q      <= ~vect;
      req_hi_q   <= 1'b0;
      req_slot_q <= first_of(lo_req);
    end else begin
      req_q      <= 1'b0;
      req_hi_q   <= 1'b0;
      req_slot_q <= req_slot_q;
    end
  end

  // After a return one more instruction must finish before any call
  // Without it a flag left set would re-enter before the interrupted
  // program made any progress
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hold_q <= 1'b0;
    end else if (reti_done_i) begin
      hold_q <= 1'b1;
    end else if (instr_done_i) begin
      hold_q <= 1'b0;
    end
  end

  // Call sequencer: four clocks of call after the detect clock
  // Vector and slot stand until the next call, so the core may read them
  // at any point of the routine
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q        <= ST_IDLE;
      cnt_q       <= '0;
      call_o      <= 1'b0;
      call_done_o <= 1'b0;
      vector_o    <= '0;
      call_slot_o <= '0;
    end else begin
      call_done_o <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (vect) begin
            st_q        <= ST_CALL;
            cnt_q       <= CALL_CYC - 3'h1;
            call_o      <= 1'b1;
            vector_o    <= vec_of(req_slot_q);
            call_slot_o <= req_slot_q;
          end
        end
        ST_CALL: begin
          if (cnt_q == 3'h0) begin
            st_q        <= ST_IDLE;
            call_o      <= 1'b0;
            call_done_o <= 1'b1;
          end
          cnt_q <= cnt_q - 3'h1;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // In-service markers; a return ends the higher active level
  // A return never meets a vectoring: vectoring needs an instruction end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      insvc_q <= 2'b00;
    end else if (vect) begin
      insvc_q[req_hi_q] <= 1'b1;
    end else if (reti_done_i) begin
      if (insvc_q[1]) insvc_q[1] <= 1'b0;
      else insvc_q[0] <= 1'b0;
    end
  end

  // Page register; vectoring switches page when auto paging is on
  // A bus write in the vectoring cycle loses to the automatic switch
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      auto_pg_q <= 1'b0;
      page_q    <= 2'h0;
    end else if (vect && auto_pg_q) begin
      page_q <= page_of(req_slot_q);
    end else if (wr && wb_adr_i == A_PAGE) begin
      auto_pg_q <= wb_dat_i[0];
      page_q    <= wb_dat_i[4:3];
    end
  end

  // Registered copies for the core
  // Limitation: the core sees page and markers one clock late
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      special_reg_page_o <= 2'h0;
      in_service_o       <= 2'b00;
    end else begin
      special_reg_page_o <= page_q;
      in_service_o       <= insvc_q;
    end
  end
endmodule : irq_ctrl

//--- rtl/irq_ctrl_pkg.sv
// Constants for the two-level vectored interrupt controller.
// Assumes a 32-bit classic Wishbone register port and 21 priority slots.
package irq_ctrl_pkg;
  localparam int NSLOT = 21;
  localparam int VW    = 16;
  // Register byte addresses
  localparam logic [7:0] A_TIMER_CONTROL_REG = 8'h00;
  localparam logic [7:0] A_IE   = 8'h04;
  localparam logic [7:0] A_EIEA = 8'h08;
  localparam logic [7:0] A_EIEB = 8'h0c;
  localparam logic [7:0] A_IP   = 8'h10;
  localparam logic [7:0] A_EIPA = 8'h14;
  localparam logic [7:0] A_EIPB = 8'h18;
  localparam logic [7:0] A_PEND = 8'h1c;
  localparam logic [7:0] A_PAGE = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  // Timer control field positions, then the global enable bit of main enable
  localparam int B_EDGE0 = 0;
  localparam int B_PEND0 = 1;
  localparam int B_EDGE1 = 2;
  localparam int B_PEND1 = 3;
  localparam int B_TF0   = 5;
  localparam int B_TF1   = 7;
  localparam int B_GEN   = 7;
  // Slot numbers of sources with special handling
  localparam int S_EXT0 = 0;
  localparam int S_TF0  = 1;
  localparam int S_EXT1 = 2;
  localparam int S_TF1  = 3;
  localparam int S_CAN  = 19;
  // Sources whose flags clear on vectoring
  localparam logic [20:0] HW_CLR = 21'h08000f;
  // Slot 13 holds no source
  localparam logic [20:0] SLOT_USED = 21'h1fdfff;
  // Vector layout
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] VEC_S17  = 16'h0093;
  localparam logic [15:0] VEC_S18  = 16'h008b;
  // Call and reset values
  localparam logic [2:0] CALL_CYC = 3'h4;
  localparam logic [7:0] RST_ZERO = 8'h00;
  typedef enum {ST_IDLE, ST_CALL} call_st_t;
endpackage : irq_ctrl_pkg

//--- test/core_model.sv
// Core sequencer model: instruction boundaries, call acceptance, returns.
// Assumes call_done_o marks entry to a routine of ISR_LEN cycles.
`timescale 1ns/1ps
module core_model #(
  parameter int ISR_LEN = 60
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  // Controller side
  input  wire logic call_o,
  input  wire logic call_done_o,
  output logic      instr_done_i,
  output logic      reti_done_i
);
  int unsigned gap;
  int unsigned depth;
  int unsigned left [2];
  // One instruction ends every third cycle; none while a call runs
  always @(posedge ref_clk_i) begin
    instr_done_i <= 1'b0;
    reti_done_i  <= 1'b0;
    if (srst_i) begin
      gap = 0;
      depth = 0;
    end else if (call_done_o && depth < 2) begin
      left[depth] = ISR_LEN;
      depth++;
    end else if (depth > 0 && left[depth-1] == 0) begin
      reti_done_i <= 1'b1; // Never in the same cycle as an instruction end
      depth--;
    end else begin
      if (depth > 0) left[depth-1]--;
      gap = (gap == 2) ? 0 : gap + 1;
      if (gap == 0 && !call_o) instr_done_i <= 1'b1;
    end
  end
endmodule : core_model

//--- test/irq_ctrl_properties.sv
// Checker for call timing, vectors, markers and bus answer of irq_ctrl.
// Assumes it is bound to irq_ctrl and sees only its ports.
`timescale 1ns/1ps
module irq_ctrl_chk import irq_ctrl_pkg::*; (
  input wire logic        ref_clk_i,
  input wire logic        srst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_done_i,
  input wire logic        reti_done_i,
  input wire logic        call_o,
  input wire logic        call_done_o,
  input wire logic [15:0] vector_o,
  input wire logic [4:0]  call_slot_o,
  input wire logic [1:0]  in_service_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic hold_q;
  // A return arms the hold; the next instruction end spends it
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) hold_q <= 1'b0;
    else if (reti_done_i) hold_q <= 1'b1;
    else if (instr_done_i) hold_q <= 1'b0;
  end
  // Two slots sit out of step with the regular vector spacing
  function automatic logic [15:0] vexp(logic [4:0] s);
    if (s == 5'd17) return VEC_S17;
    if (s == 5'd18) return VEC_S18;
    return VEC_BASE + VEC_STEP * {11'h0, s};
  endfunction : vexp
  a_call_len: assert property (
    $rose(call_o) |-> call_o [*4] ##1 (!call_o && call_done_o)) else $error("bad call length");
  a_call_edge: assert property (
    $rose(call_o) |-> $past(instr_done_i)) else $error("call off boundary");
  a_vec_map: assert property (
    $rose(call_o) |-> vector_o == vexp(call_slot_o)) else $error("wrong vector");
  a_vec_hold: assert property (
    !$rose(call_o) |-> $stable(vector_o)) else $error("vector moved");
  a_ret_hold: assert property (
    $rose(call_o) |-> !$past(hold_q)) else $error("call right after return");
  a_marker_on: assert property (
    $rose(call_o) |=> in_service_o != 2'b00) else $error("no marker");
  a_high_final: assert property (
    in_service_o[1] && $past(in_service_o[1]) |-> !$rose(call_o)) else $error("high preempted");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  c_high: cover property ($rose(call_o) && in_service_o == 2'b10);
  c_slot20: cover property ($rose(call_o) && call_slot_o == 5'd20);
  c_ret: cover property (reti_done_i);
endmodule : irq_ctrl_chk

bind irq_ctrl irq_ctrl_chk chk_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .instr_done_i(instr_done_i),
  .reti_done_i(reti_done_i), .call_o(call_o), .call_done_o(call_done_o),
  .vector_o(vector_o), .call_slot_o(call_slot_o), .in_service_o(in_service_o));

//--- test/tb_irq_ctrl.sv
// Self-checking bench for irq_ctrl driven over classic Wishbone.
// Assumes core_model supplies instruction ends and returns.
`timescale 1ns/1ps
module tb_irq_ctrl;
  import irq_ctrl_pkg::*;
  logic ref_clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic ext_irq_pin_zero_n_i, ext_irq_pin_one_n_i, instr_done_i, reti_done_i;
  logic call_o, call_done_o;
  logic [NSLOT-1:0] periph_set_i;
  logic [VW-1:0] vector_o;
  logic [4:0] call_slot_o;
  logic [1:0] special_reg_page_o, in_service_o;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  irq_ctrl dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_irq_pin_zero_n_i(ext_irq_pin_zero_n_i), .ext_irq_pin_one_n_i(ext_irq_pin_one_n_i),
    .periph_set_i(periph_set_i), .instr_done_i(instr_done_i), .reti_done_i(reti_done_i),
    .call_o(call_o), .call_done_o(call_done_o), .vector_o(vector_o),
    .call_slot_o(call_slot_o), .special_reg_page_o(special_reg_page_o),
    .in_service_o(in_service_o));
  core_model #(.ISR_LEN(60)) core_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .call_o(call_o), .call_done_o(call_done_o), .instr_done_i(instr_done_i),
    .reti_done_i(reti_done_i));
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until the edge that samples ack high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask : rdc
  task automatic wait_call(input logic [31:0] v, input logic [31:0] s);
    do @(posedge ref_clk_i); while (call_o !== 1'b1);
    chk({16'h0, vector_o}, v);
    chk({27'h0, call_slot_o}, s);
    do @(posedge ref_clk_i); while (call_done_o !== 1'b1);
  endtask : wait_call
  task automatic wait_idle();
    do @(posedge ref_clk_i); while (in_service_o !== 2'b00);
  endtask : wait_idle
  task automatic t_edge0();
    wr(A_TIMER_CONTROL_REG, 32'h1);
    wr(A_IE, 32'h81);
    ext_irq_pin_zero_n_i <= 1'b0;
    wait_call(32'h3, 32'h0);
    rdc(A_TIMER_CONTROL_REG, 32'h1);
    ext_irq_pin_zero_n_i <= 1'b1;
    wait_idle();
    wr(A_IE, 32'h82);
    periph_set_i <= 21'h2; // Timer zero overflow pulse
    @(posedge ref_clk_i);
    periph_set_i <= '0;
    wait_call(32'hb, 32'h1);
    rdc(A_TIMER_CONTROL_REG, 32'h1);
    wait_idle();
  endtask : t_edge0
  task automatic t_level1();
    wr(A_TIMER_CONTROL_REG, 32'h0);
    wr(A_IE, 32'h0);
    ext_irq_pin_one_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rdc(A_TIMER_CONTROL_REG, 32'h8);
    ext_irq_pin_one_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rdc(A_TIMER_CONTROL_REG, 32'h0);
  endtask : t_level1
  task automatic t_global();
    wr(A_PAGE, 32'h1);
    wr(A_EIEB, 32'h40);
    wr(A_PEND, 32'h100000);
    repeat (30) @(posedge ref_clk_i);
    chk({31'h0, call_o}, 32'h0);
    chk({30'h0, in_service_o}, 32'h0);
    wr(A_IE, 32'h80);
    wait_call(32'ha3, 32'd20);
    chk({30'h0, special_reg_page_o}, 32'h1);
    rdc(A_PAGE, 32'h9);
    rdc(A_PEND, 32'h100000);
    wait_call(32'ha3, 32'd20);
    wr(A_PEND, 32'h0);
    wait_idle();
    wr(A_EIEB, 32'h0);
  endtask : t_global
  task automatic t_order(input logic [31:0] ip, input logic [31:0] s1, input logic [31:0] s2);
    wr(A_IE, 32'h0);
    wr(A_IP, ip);
    wr(A_PEND, 32'h30);
    wr(A_IE, 32'hb0);
    wait_call(32'h3 + 32'h8 * s1, s1);
    chk({30'h0, in_service_o}, (ip != 0) ? 32'h2 : 32'h1);
    chk({30'h0, special_reg_page_o}, 32'h0);
    wr(A_PEND, 32'h1 << s2);
    wait_call(32'h3 + 32'h8 * s2, s2);
    wr(A_PEND, 32'h0);
    wait_idle();
  endtask : t_order
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Cuts a hang short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    srst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    periph_set_i = '0;
    ext_irq_pin_zero_n_i = 1'b1;
    ext_irq_pin_one_n_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    rdc(A_IP, 32'h0);
    rdc(A_EIPB, 32'h0);
    t_edge0();
    t_level1();
    t_global();
    t_order(32'h0, 32'd4, 32'd5);
    t_order(32'h20, 32'd5, 32'd4);
    give_verdict();
  end
endmodule : tb_irq_ctrl
